/* testbench/pusq_sequencer_test.sv */
// self-checking bench for the power-up and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module pusq_sequencer_test import pusq_pkg::*; ;
	// clock, reset and counters
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	int cyc = 0;
	int n_fail = 0;
	int n_tests = 0;
	int n;
	// supervisor commands and device pins
	logic supplyOk = 1'b1;
	logic ioOk = 1'b1;
	logic ioLow = 1'b0;
	logic porCmdN = 1'b0;
	logic extPullN = 1'b1;
	logic vccOkIn, vccioOkIn, vmonIoLowIn, powerOnResetInN, warmResetIn;
	logic warmResetOut, warmResetOe, cpuResetOut, irqOut;
	logic [31:0] cpuBootAddr, regRdData;
	pusq_req_t resetReq = '0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	// probe cycles after por release, margin of 9 around the first phase edge, 8 around the others
	localparam int PT[10] = '{40, 58, 1073, 1089, 2233, 2249, 2921,
		2937, 3538, 3554};
	localparam int ST[10] = '{1, 2, 2, 4, 4, 8, 8, 16, 16, 32};
	// warm reset sources: six request bits, then software, then pin
	localparam logic [5:0] WR[6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h01,
		6'h02};
	localparam logic [7:0] WA[8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04,
		8'h04, 8'h00, 8'h00};
	localparam logic [31:0] WE[8] = '{32'h0000_A000, 32'h0000_2000,
		32'h0000_0020, 32'h0000_0001, 32'h0000_0100, 32'h0000_0200,
		32'h0000_0010, 32'h0000_0008};

	pusq_supervisor sup (
		.supplyOk, .ioOk, .ioLow, .porCmdN, .extPullN, .warmResetOe,
		.vccOkIn, .vccioOkIn, .vmonIoLowIn, .powerOnResetInN, .warmResetIn
	);

	pusq_sequencer dut (
		.clk_sys, .rst, .vccOkIn, .vccioOkIn, .vmonIoLowIn,
		.powerOnResetInN, .warmResetIn, .warmResetOut, .warmResetOe,
		.resetReqIn(resetReq), .cpuResetOut, .cpuBootAddr, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .irqOut
	);

	// 100 MHz clock and cycle count
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			n_fail++;
			$display("mismatch t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	// register port: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] want);
		logic [31:0] v;
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 v = regRdData;
		@(posedge clk_sys);
		chk(v, want);
	endtask

	// release por and probe the phase walk up to cpu release
	task automatic boot();
		int t0;
		porCmdN <= 1'b1;
		t0 = cyc;
		for (int i = 0; i < 10; i++) begin
			while (cyc < t0 + PT[i]) @(posedge clk_sys);
			rchk(8'h14, ST[i]);
			chk({31'b0, warmResetOe}, i < 9);
			chk({31'b0, cpuResetOut}, i < 9);
		end
	endtask

	// one warm reset source; counts how long the pin is pulled
	task automatic warm(input int i);
		int hi;
		int lo;
		hi = 0;
		// pin requests stay asserted through the 48-cycle filter release
		lo = (i < 7) ? 32 : 80;
		if (i < 6) resetReq <= pusq_req_t'(WR[i]);
		else if (i == 6) begin
			regAddr <= 8'h10;
			regWrData <= 32'h0000_0001;
			regWr <= 1'b1;
		end else extPullN <= 1'b0;
		for (int m = 0; m < 140; m++) begin
			@(posedge clk_sys);
			resetReq <= '0;
			regWr <= 1'b0;
			if (m == 51) extPullN <= 1'b1;
			#1 if (warmResetOe === 1'b1) hi++;
			if (m == (i < 7 ? 0 : 48)) chk({31'b0, warmResetOe}, 1);
		end
		@(posedge clk_sys);
		chk({31'b0, hi >= lo && hi <= lo + 1}, 1);
		rchk(WA[i], WE[i]);
		wr(WA[i], WE[i]);
		rchk(WA[i], 32'h0000_0000);
	endtask

	// low pulse on por or the warm pin; counts cycles of cpu reset
	task automatic glitch(input bit por, input int len, output int cnt);
		cnt = 0;
		for (int m = 0; m < len + 60; m++) begin
			@(posedge clk_sys);
			if (por) porCmdN <= (m >= len);
			else extPullN <= (m >= len);
			#1 if (cpuResetOut === 1'b1) cnt++;
		end
		@(posedge clk_sys);
	endtask

	task automatic final_report();
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		tick(4);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'b0, warmResetOut}, 0);
		chk(cpuBootAddr, 32'h0000_0000);
		// por released but io supply low: must stay idle
		ioOk <= 1'b0;
		porCmdN <= 1'b1;
		tick(200);
		rchk(8'h14, 32'h0000_0001);
		porCmdN <= 1'b0;
		ioOk <= 1'b1;
		tick(60);
		boot();
		// interrupt: done event, masked then unmasked, cleared by read
		chk({31'b0, irqOut}, 0);
		wr(8'h0C, 32'h0000_0003);
		tick(1);
		chk({31'b0, irqOut}, 1);
		rchk(8'h08, 32'h0000_0001);
		chk({31'b0, irqOut}, 0);
		rchk(8'h20, 32'h0000_0000);
		for (int i = 0; i < 8; i++) warm(i);
		rchk(8'h08, 32'h0000_0002);
		// short lows are ignored, long por low resets
		glitch(0, 40, n);
		chk(n, 0);
		glitch(1, 40, n);
		chk(n, 0);
		ioLow <= 1'b1;
		tick(3);
		rchk(8'h14, 32'h0000_0001);
		ioLow <= 1'b0;
		tick(3700);
		glitch(1, 210, n);
		chk({31'b0, n > 0}, 1);
		// abort in the fuse phase, restart from oscillator check
		tick(1400);
		glitch(1, 210, n);
		rchk(8'h14, 32'h0000_0002);
		final_report();
	end

	// watchdog against a hang
	initial begin
		tick(20000);
		n_fail++;
		final_report();
	end
endmodule // pusq_sequencer_test
`default_nettype wire

/* testbench/pusq_supervisor.sv */
// supply supervisor and warm reset wire model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module pusq_supervisor (
	// commands from the bench
	input wire logic supplyOk,
	input wire logic ioOk,
	input wire logic ioLow,
	input wire logic porCmdN,
	input wire logic extPullN,
	// device pins
	input wire logic warmResetOe,
	output logic vccOkIn,
	output logic vccioOkIn,
	output logic vmonIoLowIn,
	output logic powerOnResetInN,
	output logic warmResetIn
);
	// supplies reported as commanded, no gating so the device must decide
	assign vccOkIn = supplyOk;
	assign vccioOkIn = ioOk;
	assign vmonIoLowIn = ioLow;
	assign powerOnResetInN = porCmdN;
	// open-drain wire with pull-up; either party may pull it low
	assign warmResetIn = !(warmResetOe | !extPullN);
endmodule // pusq_supervisor
`default_nettype wire

/* verilog/pusq_consts.svh */
// constants of the power-up and reset sequencer
`ifndef PUSQ_CONSTS_SVH
`define PUSQ_CONSTS_SVH

// oscillator clock period and glitch filter window
`define PUSQ_CLK_NS 10
`define PUSQ_FILT_MIN_NS 475
`define PUSQ_FILT_MAX_NS 2000
`define PUSQ_FILT_CYC ((`PUSQ_FILT_MIN_NS + `PUSQ_CLK_NS - 1) / `PUSQ_CLK_NS)

// start-up phase lengths in oscillator cycles
`define PUSQ_OSC_CYC 12'h0_408
`define PUSQ_FUSE_CYC 12'h0_488
`define PUSQ_PUMP_CYC 12'h0_2B0
`define PUSQ_BANK_CYC 12'h0_269

// warm reset stretch lengths
`define PUSQ_POR_STRETCH_CYC 12'h0_8D0
`define PUSQ_WARM_STRETCH_PERIPHERAL_BUS_CLOCK 6'h20
`define PUSQ_PERIPHERAL_BUS_CLOCK_DIV 1

// cpu boot address
`define PUSQ_BOOT_ADDR 32'h0000_0000

// register byte addresses
`define PUSQ_ADDR_EXC_STAT 8'h00
`define PUSQ_ADDR_GLB_STAT 8'h04
`define PUSQ_ADDR_INT_STAT 8'h08
`define PUSQ_ADDR_INT_MASK 8'h0C
`define PUSQ_ADDR_CTRL 8'h10
`define PUSQ_ADDR_SEQ_STATE 8'h14

// exception status bits
`define PUSQ_EXC_POWERUP 15
`define PUSQ_EXC_WDOG 13
`define PUSQ_EXC_SELFTEST 5
`define PUSQ_EXC_SOFT 4
`define PUSQ_EXC_EXTERNAL 3

// global status bits
`define PUSQ_GLB_OSCFAIL 0
`define PUSQ_GLB_SLIP0 8
`define PUSQ_GLB_SLIP1 9

// interrupt status bits and control bits
`define PUSQ_INT_SEQDONE 0
`define PUSQ_INT_WARM 1
`define PUSQ_CTRL_SWRST 0

`endif

/* verilog/pusq_glitch_filter.sv */
// glitch filter: output follows a level only after it stands LEN cycles
`timescale 1ns/10ps
`default_nettype none
module pusq_glitch_filter #(
	parameter int LEN = 48,
	parameter bit INIT = 1'b1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// level in, filtered level out
	input wire logic levelIn,
	output logic levelOut
);

	initial begin
		if (LEN < 2 || LEN > 255) begin
			$error("pusq_glitch_filter: LEN out of range");
		end
	end

	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic out_ff;
	logic nxt_out;

	// count cycles that disagree with the output; any agreement restarts
	always_comb begin
		nxt_cnt = 8'h00;
		nxt_out = out_ff;
		if (levelIn != out_ff) begin
			if (cnt_ff == 8'(LEN - 1)) begin
				nxt_out = levelIn;
			end else begin
				nxt_cnt = cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
			out_ff <= INIT;
		end else begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign levelOut = out_ff;

endmodule // pusq_glitch_filter
`default_nettype wire

/* verilog/pusq_pkg.sv */
// types of the power-up and reset sequencer
package pusq_pkg;

	// start-up sequence states, one-hot
	typedef enum logic [5:0] {
		PUSQ_HOLD = 6'b00_0001,
		PUSQ_OSC  = 6'b00_0010,
		PUSQ_FUSE = 6'b00_0100,
		PUSQ_PUMP = 6'b00_1000,
		PUSQ_BANK = 6'b01_0000,
		PUSQ_RUN  = 6'b10_0000
	} pusq_state_t;

	// reset requests from inside the chip
	typedef struct packed {
		logic watchdog;
		logic debugger;
		logic selfTest;
		logic oscFail;
		logic [1:0] pllSlip;
	} pusq_req_t;

endpackage

/* verilog/pusq_sequencer.sv */
// power-up and reset sequencer with reset cause flags
//
// What this block does
// - start only when both supplies are good and power-on reset is released
// - spend 1032 cycles on oscillator check, then 1160 on fuse autoload
// - then flash pump power-up 688 cycles, then flash bank 617, in order
// - at sequence end release cpu reset; first fetch from address zero
// - power-on reset input ignores lows under 475 ns, acts above 2000 ns
// - any reset drives the warm reset pin low, open drain, never high
// - an outside party may pull the warm reset pin low to request reset
// - warm reset input ignores lows under 475 ns, acts above 2000 ns
// - pin stays low at least 2256 cycles after power-on reset releases
// - other resets hold the pin low at least 32 peripheral clocks
// - power-up sets exception bit 15; watchdog or debugger sets bit 13
// - self-test reset sets bit 5, software bit 4, external bit 3
// - oscillator failure sets global bit 0; pll slip bits 8 and 9
// - low i/o supply from the voltage monitor acts as power-on reset
`timescale 1ns/10ps
`default_nettype none
`include "pusq_consts.svh"
module pusq_sequencer import pusq_pkg::*; #(
	parameter int PERIPHERAL_BUS_CLOCK_DIV = `PUSQ_PERIPHERAL_BUS_CLOCK_DIV
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// supplies and power-on reset
	input wire logic vccOkIn,
	input wire logic vccioOkIn,
	input wire logic vmonIoLowIn,
	input wire logic powerOnResetInN,
	// warm reset open-drain pin
	input wire logic warmResetIn,
	output logic warmResetOut,
	output logic warmResetOe,
	// internal reset requests
	input wire pusq_req_t resetReqIn,
	// cpu side
	output logic cpuResetOut,
	output logic [31:0] cpuBootAddr,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// interrupt
	output logic irqOut
);

	initial begin
		if (PERIPHERAL_BUS_CLOCK_DIV < 1 || PERIPHERAL_BUS_CLOCK_DIV > 16) begin
			$error("pusq_sequencer: PERIPHERAL_BUS_CLOCK_DIV must be 1 to 16");
		end
	end

	// register address decode, used by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	logic porFilt;
	logic extFilt;
	logic porActive;
	logic extLowRaw;
	logic vclkEn;
	logic warmEvent;
	logic swReq;
	logic seqDone;

	// power-on input is active low; filter the active level
	pusq_glitch_filter #(.LEN(`PUSQ_FILT_CYC), .INIT(1'b1)) u_porFilt (
		.clk_sys(clk_sys),
		.rst(rst),
		.levelIn(!powerOnResetInN),
		.levelOut(porFilt)
	);

	// our own drive is masked out so we never retrigger on ourselves
	assign extLowRaw = !warmResetIn && !warmResetOe;
	pusq_glitch_filter #(.LEN(`PUSQ_FILT_CYC), .INIT(1'b0)) u_extFilt (
		.clk_sys(clk_sys),
		.rst(rst),
		.levelIn(extLowRaw),
		.levelOut(extFilt)
	);

	// any supply condition or power-on reset holds the sequence
	assign porActive = porFilt || vmonIoLowIn || !vccOkIn || !vccioOkIn;

	// peripheral clock enable divider
	logic [3:0] div_ff;
	logic [3:0] nxt_div;
	always_comb begin
		nxt_div = (div_ff == 4'(PERIPHERAL_BUS_CLOCK_DIV - 1)) ? 4'h0 : div_ff + 4'h1;
		// a request restarts the phase so the stretch is never cut short
		if (warmEvent) begin
			nxt_div = (PERIPHERAL_BUS_CLOCK_DIV == 1) ? 4'h0 : 4'h1;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= nxt_div;
		end
	end
	assign vclkEn = (div_ff == 4'h0);

	// start-up state machine with phase counter
	pusq_state_t state_ff;
	pusq_state_t nxt_state;
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		seqDone = 1'b0;
		if (porActive) begin
			nxt_state = PUSQ_HOLD;
			nxt_cnt = 12'h000;
		end else begin
			case (state_ff)
				PUSQ_HOLD: begin
					nxt_state = PUSQ_OSC;
					nxt_cnt = `PUSQ_OSC_CYC - 12'h001;
				end
				PUSQ_OSC: begin
					if (cnt_ff == 12'h000) begin
						nxt_state = PUSQ_FUSE;
						nxt_cnt = `PUSQ_FUSE_CYC - 12'h001;
					end else begin
						nxt_cnt = cnt_ff - 12'h001;
					end
				end
				PUSQ_FUSE: begin
					if (cnt_ff == 12'h000) begin
						nxt_state = PUSQ_PUMP;
						nxt_cnt = `PUSQ_PUMP_CYC - 12'h001;
					end else begin
						nxt_cnt = cnt_ff - 12'h001;
					end
				end
				PUSQ_PUMP: begin
					if (cnt_ff == 12'h000) begin
						nxt_state = PUSQ_BANK;
						nxt_cnt = `PUSQ_BANK_CYC - 12'h001;
					end else begin
						nxt_cnt = cnt_ff - 12'h001;
					end
				end
				PUSQ_BANK: begin
					if (cnt_ff == 12'h000) begin
						nxt_state = PUSQ_RUN;
						seqDone = 1'b1;
					end else begin
						nxt_cnt = cnt_ff - 12'h001;
					end
				end
				PUSQ_RUN: begin
					nxt_cnt = 12'h000;
				end
				default: begin
					nxt_state = PUSQ_HOLD;
					nxt_cnt = 12'h000;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= PUSQ_HOLD;
			cnt_ff <= 12'h000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// warm reset stretchers: oscillator cycles after power-on, peripheral_bus_clock otherwise
	logic [11:0] porStr_ff;
	logic [11:0] nxt_porStr;
	logic [5:0] warmStr_ff;
	logic [5:0] nxt_warmStr;
	assign warmEvent = (state_ff == PUSQ_RUN) && !porActive &&
		(|resetReqIn || extFilt || swReq);
	always_comb begin
		nxt_porStr = porStr_ff;
		nxt_warmStr = warmStr_ff;
		if (porActive) begin
			nxt_porStr = `PUSQ_POR_STRETCH_CYC;
		end else if (porStr_ff != 12'h000) begin
			nxt_porStr = porStr_ff - 12'h001;
		end
		if (warmEvent) begin
			nxt_warmStr = `PUSQ_WARM_STRETCH_PERIPHERAL_BUS_CLOCK;
		end else if (vclkEn && warmStr_ff != 6'h00) begin
			nxt_warmStr = warmStr_ff - 6'h01;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			porStr_ff <= `PUSQ_POR_STRETCH_CYC;
			warmStr_ff <= 6'h00;
		end else begin
			porStr_ff <= nxt_porStr;
			warmStr_ff <= nxt_warmStr;
		end
	end

	// open drain: only ever pulls low
	assign warmResetOut = 1'b0;
	assign warmResetOe = porActive || state_ff != PUSQ_RUN ||
		porStr_ff != 12'h000 || warmStr_ff != 6'h00;
	assign cpuResetOut = porActive || state_ff != PUSQ_RUN ||
		warmStr_ff != 6'h00;
	assign cpuBootAddr = `PUSQ_BOOT_ADDR;

	// cause flags, interrupt status and mask; set wins over clear
	logic [15:0] exc_ff;
	logic [15:0] nxt_exc;
	logic [9:0] glb_ff;
	logic [9:0] nxt_glb;
	logic [1:0] int_ff;
	logic [1:0] nxt_int;
	logic [1:0] mask_ff;
	logic [1:0] nxt_mask;
	logic [15:0] excSet;
	logic [9:0] glbSet;
	logic inRun;
	assign inRun = (state_ff == PUSQ_RUN) && !porActive;
	assign swReq = regWr && hit(regAddr, `PUSQ_ADDR_CTRL) &&
		regWrData[`PUSQ_CTRL_SWRST];
	always_comb begin
		excSet = 16'h0000;
		glbSet = 10'h000;
		excSet[`PUSQ_EXC_POWERUP] = porActive;
		excSet[`PUSQ_EXC_WDOG] = inRun &&
			(resetReqIn.watchdog || resetReqIn.debugger);
		excSet[`PUSQ_EXC_SELFTEST] = inRun && resetReqIn.selfTest;
		excSet[`PUSQ_EXC_SOFT] = inRun && swReq;
		excSet[`PUSQ_EXC_EXTERNAL] = inRun && extFilt;
		glbSet[`PUSQ_GLB_OSCFAIL] = inRun && resetReqIn.oscFail;
		glbSet[`PUSQ_GLB_SLIP0] = inRun && resetReqIn.pllSlip[0];
		glbSet[`PUSQ_GLB_SLIP1] = inRun && resetReqIn.pllSlip[1];
		nxt_exc = exc_ff;
		nxt_glb = glb_ff;
		nxt_int = int_ff;
		nxt_mask = mask_ff;
		// write one to clear exc and glb status, read clears int status; warm resets never clear these
		if (regWr && hit(regAddr, `PUSQ_ADDR_EXC_STAT)) begin
			nxt_exc = exc_ff & ~regWrData[15:0];
		end
		if (regWr && hit(regAddr, `PUSQ_ADDR_GLB_STAT)) begin
			nxt_glb = glb_ff & ~regWrData[9:0];
		end
		if (regWr && hit(regAddr, `PUSQ_ADDR_INT_MASK)) begin
			nxt_mask = regWrData[1:0];
		end
		if (regRd && hit(regAddr, `PUSQ_ADDR_INT_STAT)) begin
			nxt_int = 2'b00;
		end
		nxt_exc = nxt_exc | excSet;
		nxt_glb = nxt_glb | glbSet;
		nxt_int[`PUSQ_INT_SEQDONE] = nxt_int[`PUSQ_INT_SEQDONE] | seqDone;
		nxt_int[`PUSQ_INT_WARM] = nxt_int[`PUSQ_INT_WARM] | warmEvent;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			exc_ff <= 16'h0000;
			glb_ff <= 10'h000;
			int_ff <= 2'b00;
			mask_ff <= 2'b00;
		end else begin
			exc_ff <= nxt_exc;
			glb_ff <= nxt_glb;
			int_ff <= nxt_int;
			mask_ff <= nxt_mask;
		end
	end
	assign irqOut = |(int_ff & mask_ff);

	// read data register; unmapped addresses read zero
	logic [31:0] rd_ff;
	logic [31:0] nxt_rd;
	always_comb begin
		nxt_rd = 32'h0000_0000;
		if (regRd) begin
			case (1'b1)
				hit(regAddr, `PUSQ_ADDR_EXC_STAT): nxt_rd[15:0] = exc_ff;
				hit(regAddr, `PUSQ_ADDR_GLB_STAT): nxt_rd[9:0] = glb_ff;
				hit(regAddr, `PUSQ_ADDR_INT_STAT): nxt_rd[1:0] = int_ff;
				hit(regAddr, `PUSQ_ADDR_INT_MASK): nxt_rd[1:0] = mask_ff;
				hit(regAddr, `PUSQ_ADDR_SEQ_STATE): nxt_rd[5:0] = state_ff;
				default: nxt_rd = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_ff <= 32'h0000_0000;
		end else begin
			rd_ff <= nxt_rd;
		end
	end
	assign regRdData = rd_ff;

	// helper counters for the checks below
	localparam int OSC_LAST = 1031;
	localparam int FUSE_LAST = 1159;
	localparam int PUMP_LAST = 687;
	localparam int BANK_LAST = 616;
	localparam int POR_HOLD = 2256;
	localparam int FILT_CYC = `PUSQ_FILT_CYC;
	int dwell;
	int relSince;
	int lowRun;
	int oeRun;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dwell <= 0;
			relSince <= 0;
			lowRun <= 0;
			oeRun <= 0;
		end else begin
			dwell <= (nxt_state != state_ff) ? 0 : dwell + 1;
			relSince <= porActive ? 0 : (relSince < 9999 ? relSince + 1 : 9999);
			lowRun <= powerOnResetInN ? 0 : (lowRun < 999 ? lowRun + 1 : 999);
			oeRun <= !warmResetOe ? 0 : (oeRun < 9999 ? oeRun + 1 : 9999);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_bankEnd;
		state_ff == PUSQ_BANK && dwell == BANK_LAST && !porActive;
	endsequence
	sequence s_running;
		!cpuResetOut && cpuBootAddr == 32'h0000_0000;
	endsequence

	property p_hold;
		porActive |=> state_ff == PUSQ_HOLD && cpuResetOut;
	endproperty
	a_hold: assert property (p_hold) else $error("sequence not held");
	property p_oscLen;
		state_ff == PUSQ_OSC ##1 state_ff == PUSQ_FUSE |->
			$past(dwell) == OSC_LAST;
	endproperty
	a_oscLen: assert property (p_oscLen) else $error("osc phase length");
	property p_fuseLen;
		state_ff == PUSQ_PUMP && $past(state_ff) == PUSQ_FUSE |->
			$past(dwell) == FUSE_LAST;
	endproperty
	a_fuseLen: assert property (p_fuseLen) else $error("fuse length");
	property p_pumpLen;
		state_ff == PUSQ_BANK && $past(state_ff) != PUSQ_BANK |->
			$past(state_ff) == PUSQ_PUMP && $past(dwell) == PUMP_LAST;
	endproperty
	a_pumpLen: assert property (p_pumpLen) else $error("pump phase");
	property p_release;
		s_bankEnd ##0 (warmStr_ff == 6'h00) |=> s_running;
	endproperty
	a_release: assert property (p_release) else $error("cpu not released");
	property p_porFilt;
		lowRun > FILT_CYC |-> porFilt;
	endproperty
	a_porFilt: assert property (p_porFilt) else $error("por not seen");
	property p_pinLow;
		(porActive || cpuResetOut) |-> warmResetOe && !warmResetOut;
	endproperty
	a_pinLow: assert property (p_pinLow) else $error("pin not low");
	property p_ext;
		extFilt && inRun |=> warmResetOe && cpuResetOut ##0
			exc_ff[`PUSQ_EXC_EXTERNAL];
	endproperty
	a_ext: assert property (p_ext) else $error("external reset missed");
	property p_porStretch;
		!warmResetOe |-> relSince >= POR_HOLD;
	endproperty
	a_porStretch: assert property (p_porStretch) else $error("short");
	property p_warmStretch;
		$fell(warmResetOe) |-> oeRun >= 32 * PERIPHERAL_BUS_CLOCK_DIV;
	endproperty
	a_warmStretch: assert property (p_warmStretch) else $error("short");
	property p_pupFlag;
		porActive |=> exc_ff[`PUSQ_EXC_POWERUP];
	endproperty
	a_pupFlag: assert property (p_pupFlag) else $error("no pup flag");
	property p_oscFlag;
		inRun && resetReqIn.oscFail |=> glb_ff[`PUSQ_GLB_OSCFAIL];
	endproperty
	a_oscFlag: assert property (p_oscFlag) else $error("no osc flag");
	property p_keep;
		exc_ff[`PUSQ_EXC_SOFT] &&
			!(regWr && hit(regAddr, `PUSQ_ADDR_EXC_STAT)) |=>
			exc_ff[`PUSQ_EXC_SOFT];
	endproperty
	a_keep: assert property (p_keep) else $error("flag lost");

endmodule // pusq_sequencer
`default_nettype wire
